//--- common/inj_regs_defines.vh
/*
 * Register offsets, field positions, reset values and range limits for
 * the injection controller reset-and-status register bank.
 * Assumes a register-level access port decoded by word index; included
 * by bare name from the design files.
 */
// Notes on behaviour
// - writing one to total clear zeroes the volume total; zero does nothing
// - writing one to alarm clear clears latched alarms; zero does nothing
// - battery low word reports millivolts, unsigned 0 to 50000
// - alarm bit 0 unused; bits 1-3 tank shutoff, tank notify, analog in
// - alarm bits 4-8 comms loss, flow accuracy, count, input one, two
// - alarm bits 9,10 temperature, battery; 11 unused; 12-14 pressure, current
// - tank height low word in 0.01 inch counts, 0 to 14400
// - tank height meaningful only with level monitor fitted
`ifndef INJ_REGS_DEFINES_VH
`define INJ_REGS_DEFINES_VH

// ---------------------------------------------------------------
// register addresses (word index)
// ---------------------------------------------------------------
`define ADDR_TOTAL_CLEAR_HI   20'h61EF6
`define ADDR_TOTAL_CLEAR_LO   20'h61EF7
`define ADDR_ALARM_CLEAR_HI   20'h61EF8
`define ADDR_ALARM_CLEAR_LO   20'h61EF9
`define ADDR_BATT_HI          20'h61EFA
`define ADDR_BATT_LO          20'h61EFB
`define ADDR_ALARM_HI         20'h61EFC
`define ADDR_ALARM_LO         20'h61EFD
`define ADDR_HEIGHT_HI        20'h61EFE
`define ADDR_HEIGHT_LO        20'h61EFF
`define ADDR_PPV_HI           20'h61F00
`define ADDR_PPV_LO           20'h61F01
`define ADDR_PUMP_HI          20'h61F02

// ---------------------------------------------------------------
// alarm bit positions
// ---------------------------------------------------------------
`define ALM_TANK_SHUTOFF      1
`define ALM_TANK_NOTIFY       2
`define ALM_ANALOG_IN         3
`define ALM_COMMS_LOSS        4
`define ALM_FLOW_ACCURACY     5
`define ALM_COUNT_MISSED      6
`define ALM_INPUT_ONE         7
`define ALM_INPUT_TWO         8
`define ALM_TEMPERATURE       9
`define ALM_BATT_SHUTOFF      10
`define ALM_HIGH_PRESSURE     12
`define ALM_LOW_PRESSURE      13
`define ALM_OVER_CURRENT      14
`define ALM_USED_MASK         16'h77FE

// ---------------------------------------------------------------
// values and limits
// ---------------------------------------------------------------
`define ACTION_VALUE          32'h00000001
`define BATT_MAX_MV           16'hC350
`define HEIGHT_MAX            16'h3840
`define PPV_MIN               16'h0001
`define PPV_MAX               16'h270F
`define WORD_ZERO             16'h0000
`define TOTAL_RESET           32'h00000000

`endif

//--- hdl/inj_alarm_latch.v
/*
 * Sticky alarm latch: one flag per alarm source, cleared by a pulse.
 * Assumes sources are synchronous to the clock, one per alarm bit.
 */
module inj_alarm_latch #(
   parameter WIDTH = 16
) (
   input  wire             clk_in,
   input  wire             rst_in,
   input  wire             ce_in,
   input  wire [WIDTH-1:0] src_in,
   input  wire [WIDTH-1:0] used_in,
   input  wire             clear_in,
   output wire [WIDTH-1:0] flags_out
);

   // ---------------------------------------------------------------
   // per-bit sticky flags
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         // one register per bit keeps each flag to a single driver
         reg bit_ff;
         always @(posedge clk_in) begin
            if (rst_in) begin
               bit_ff <= 1'b0;
            end else if (ce_in) begin
               if (src_in[i] & used_in[i]) begin
                  bit_ff <= 1'b1;
               end else if (clear_in) begin
                  bit_ff <= 1'b0;
               end
            end
         end
         assign flags_out[i] = bit_ff;
      end
   endgenerate

endmodule

//--- hdl/inj_status_regs.v
/*
 * Reset-action and status register bank of the injection controller.
 * A Modbus front end outside this module decodes frames into single
 * 16-bit register reads and writes at word index; writes of the 32-bit
 * action registers arrive upper word then lower word.
 * The upper word of an action register is held until rewritten, so a
 * lone lower-word write of one still fires when the held word is zero.
 * Reads of the alarm lower word see the latch itself, one cycle ahead
 * of ALARM_FLAGS_OUT.
 */
`include "inj_regs_defines.vh"

module inj_status_regs #(
   parameter ADDR_W = 20
) (
   input  wire              CLK_SYS_IN,
   input  wire              RST_IN,
   input  wire              CE_IN,
   input  wire [ADDR_W-1:0] REG_ADDR_IN,
   input  wire              REG_WR_IN,
   input  wire              REG_RD_IN,
   input  wire [15:0]       REG_WDATA_IN,
   input  wire [15:0]       BATT_MV_IN,
   input  wire [15:0]       ALARM_SRC_IN,
   input  wire [15:0]       LEVEL_HEIGHT_IN,
   input  wire              LEVEL_MONITOR_OPTION_IN,
   input  wire [15:0]       PULSE_PER_VOLUME_IN,
   input  wire              VOLUME_PULSE_IN,
   input  wire [15:0]       VOLUME_STEP_IN,
   output reg  [15:0]       REG_RDATA_OUT,
   output reg               REG_RVALID_OUT,
   output reg               REG_ERR_OUT,
   output reg  [31:0]       TOTAL_VOLUME_OUT,
   output reg               TOTAL_CLEARED_OUT,
   output reg               ALARM_CLEARED_OUT,
   output reg  [15:0]       ALARM_FLAGS_OUT
);

   reg  [15:0] tot_hi_ff;
   reg  [15:0] alm_hi_ff;
   reg  [15:0] batt_ff;
   reg  [15:0] height_ff;
   reg  [15:0] ppv_ff;
   reg         alarm_clear_ff;
   reg  [15:0] nxt_rdata;
   reg         nxt_err;
   wire [15:0] flags;
   wire        wr_tot_lo;
   wire        wr_alm_lo;
   wire        wr_tot_hi;
   wire        wr_alm_hi;
   wire        tot_fire;
   wire        alm_fire;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function [15:0] clamp;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         if (v < lo) begin
            clamp = lo;
         end else if (v > hi) begin
            clamp = hi;
         end else begin
            clamp = v;
         end
      end
   endfunction

   function is_action;
      input [15:0] hi;
      input [15:0] lo;
      begin
         is_action = ({hi, lo} == `ACTION_VALUE);
      end
   endfunction

   // write strobe qualified by one register index
   function wr_hit;
      input [ADDR_W-1:0] a;
      input [ADDR_W-1:0] r;
      input              w;
      begin
         wr_hit = w & (a == r);
      end
   endfunction

   // ---------------------------------------------------------------
   // write decode
   // ---------------------------------------------------------------
   assign wr_tot_hi = wr_hit(REG_ADDR_IN, `ADDR_TOTAL_CLEAR_HI, REG_WR_IN);
   assign wr_tot_lo = wr_hit(REG_ADDR_IN, `ADDR_TOTAL_CLEAR_LO, REG_WR_IN);
   assign wr_alm_hi = wr_hit(REG_ADDR_IN, `ADDR_ALARM_CLEAR_HI, REG_WR_IN);
   assign wr_alm_lo = wr_hit(REG_ADDR_IN, `ADDR_ALARM_CLEAR_LO, REG_WR_IN);
   // an action fires only when both halves together read exactly one
   assign tot_fire  = wr_tot_lo & is_action(tot_hi_ff, REG_WDATA_IN);
   assign alm_fire  = wr_alm_lo & is_action(alm_hi_ff, REG_WDATA_IN);

   // ---------------------------------------------------------------
   // action registers
   // ---------------------------------------------------------------
   // upper words are held so the lower-word write sees the full value
   always @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         tot_hi_ff      <= `WORD_ZERO;
         alm_hi_ff      <= `WORD_ZERO;
         alarm_clear_ff <= 1'b0;
      end else if (CE_IN) begin
         if (wr_tot_hi) begin
            tot_hi_ff <= REG_WDATA_IN;
         end
         if (wr_alm_hi) begin
            alm_hi_ff <= REG_WDATA_IN;
         end
         alarm_clear_ff <= alm_fire;
      end
   end

   always @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         TOTAL_VOLUME_OUT  <= `TOTAL_RESET;
         TOTAL_CLEARED_OUT <= 1'b0;
      end else if (CE_IN) begin
         TOTAL_CLEARED_OUT <= tot_fire;
         // a clear beats a same-cycle volume pulse, which is then lost
         if (tot_fire) begin
            TOTAL_VOLUME_OUT <= `TOTAL_RESET;
         end else if (VOLUME_PULSE_IN) begin
            TOTAL_VOLUME_OUT <= TOTAL_VOLUME_OUT + {16'h0000, VOLUME_STEP_IN};
         end
      end
   end

   // ---------------------------------------------------------------
   // alarm latch
   // ---------------------------------------------------------------
   // used bit mask
   inj_alarm_latch #(
      .WIDTH     (16)
   ) u_alarms (
      .clk_in    (CLK_SYS_IN),
      .rst_in    (RST_IN),
      .ce_in     (CE_IN),
      .src_in    (ALARM_SRC_IN),
      .used_in   (`ALM_USED_MASK),
      .clear_in  (alarm_clear_ff),
      .flags_out (flags)
   );

   // ---------------------------------------------------------------
   // status sampling
   // ---------------------------------------------------------------
   // values are re-sampled only from the sensor side, never from writes
   always @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         batt_ff           <= `WORD_ZERO;
         height_ff         <= `WORD_ZERO;
         ppv_ff            <= `PPV_MIN;
         ALARM_FLAGS_OUT   <= `WORD_ZERO;
         ALARM_CLEARED_OUT <= 1'b0;
      end else if (CE_IN) begin
         batt_ff <= clamp(BATT_MV_IN, `WORD_ZERO, `BATT_MAX_MV);
         if (LEVEL_MONITOR_OPTION_IN) begin
            height_ff <= clamp(LEVEL_HEIGHT_IN, `WORD_ZERO, `HEIGHT_MAX);
         end else begin
            height_ff <= `WORD_ZERO;
         end
         ppv_ff            <= clamp(PULSE_PER_VOLUME_IN, `PPV_MIN, `PPV_MAX);
         ALARM_FLAGS_OUT   <= flags;
         ALARM_CLEARED_OUT <= alarm_clear_ff;
      end
   end

   // ---------------------------------------------------------------
   // read decode
   // ---------------------------------------------------------------
   // upper words zero
   always @* begin
      nxt_rdata = `WORD_ZERO;
      nxt_err   = 1'b0;
      case (REG_ADDR_IN)
         `ADDR_BATT_LO:   nxt_rdata = batt_ff;
         `ADDR_ALARM_LO:  nxt_rdata = flags;
         `ADDR_HEIGHT_LO: nxt_rdata = height_ff;
         `ADDR_PPV_LO:    nxt_rdata = ppv_ff;
         `ADDR_BATT_HI,
         `ADDR_ALARM_HI,
         `ADDR_HEIGHT_HI,
         `ADDR_PPV_HI,
         `ADDR_PUMP_HI:   nxt_rdata = `WORD_ZERO;
         // action registers are write-only and read as zero
         `ADDR_TOTAL_CLEAR_HI,
         `ADDR_TOTAL_CLEAR_LO,
         `ADDR_ALARM_CLEAR_HI,
         `ADDR_ALARM_CLEAR_LO: nxt_rdata = `WORD_ZERO;
         default:         nxt_err = 1'b1;
      endcase
   end

   always @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         REG_RDATA_OUT  <= `WORD_ZERO;
         REG_RVALID_OUT <= 1'b0;
         REG_ERR_OUT    <= 1'b0;
      end else if (CE_IN) begin
         REG_RVALID_OUT <= REG_RD_IN;
         REG_ERR_OUT    <= REG_RD_IN & nxt_err;
         if (REG_RD_IN) begin
            REG_RDATA_OUT <= nxt_rdata;
         end
      end
   end

endmodule

//--- test/modbus_master.sv
/* Modbus master model: single 16-bit register reads and writes.
   assumes the bank answers a read one cycle after taking it */
module modbus_master (
   input  logic        clk_in,
   input  logic        rvalid_in,
   input  logic        err_in,
   input  logic [15:0] rdata_in,
   output logic [19:0] addr_out,
   output logic        wr_out,
   output logic        rd_out,
   output logic [15:0] wdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {addr_out, wr_out, rd_out, wdata_out} = '0;
   task automatic wr_reg(input logic [19:0] a, input logic [15:0] v);
      @(negedge clk_in);
      addr_out = a;
      wdata_out = v;
      wr_out = 1'b1;
      @(negedge clk_in);
      wr_out = 1'b0;
      // released bus shows the inverse, never the stale word
      addr_out = ~a;
      wdata_out = ~v;
   endtask
   task automatic rd_reg(input logic [19:0] a, output logic [15:0] v,
                         output logic e);
      @(negedge clk_in);
      addr_out = a;
      rd_out = 1'b1;
      @(negedge clk_in);
      rd_out = 1'b0;
      addr_out = ~a;
      v = rvalid_in ? rdata_in : 16'hXXXX;
      e = err_in;
   endtask
   task automatic wr32(input logic [19:0] a, input logic [31:0] v);
      wr_reg(a, v[31:16]);
      wr_reg(a + 20'h00001, v[15:0]);
   endtask
endmodule

//--- test/status_chk_props.sv
/* concurrent checks on the status bank ports.
   assumes a single clock and a synchronous active-high reset */
`include "inj_regs_defines.vh"
module status_chk #(
   parameter ADDR_W = 20
) (
   input logic              CLK_SYS_IN,
   input logic              RST_IN,
   input logic              CE_IN,
   input logic [ADDR_W-1:0] REG_ADDR_IN,
   input logic              REG_WR_IN,
   input logic              REG_RD_IN,
   input logic [15:0]       REG_WDATA_IN,
   input logic [15:0]       BATT_MV_IN,
   input logic [15:0]       ALARM_SRC_IN,
   input logic [15:0]       LEVEL_HEIGHT_IN,
   input logic              LEVEL_MONITOR_OPTION_IN,
   input logic [15:0]       REG_RDATA_OUT,
   input logic              REG_RVALID_OUT,
   input logic [31:0]       TOTAL_VOLUME_OUT,
   input logic              TOTAL_CLEARED_OUT,
   input logic              ALARM_CLEARED_OUT,
   input logic [15:0]       ALARM_FLAGS_OUT
);
   wire rd = REG_RD_IN && CE_IN;
   wire wr = REG_WR_IN && CE_IN;
   logic [15:0] tot_hi_ff;
   logic [15:0] alm_hi_ff;
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         tot_hi_ff <= 16'h0000;
         alm_hi_ff <= 16'h0000;
      end else begin
         if (wr && REG_ADDR_IN == `ADDR_TOTAL_CLEAR_HI)
            tot_hi_ff <= REG_WDATA_IN;
         if (wr && REG_ADDR_IN == `ADDR_ALARM_CLEAR_HI)
            alm_hi_ff <= REG_WDATA_IN;
      end
   end
   default clocking cb @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (RST_IN);
   AST_BATT_LO: assert property (
      rd && REG_ADDR_IN == `ADDR_BATT_LO && $stable(BATT_MV_IN) &&
      $past(CE_IN) && !$past(RST_IN) |=> REG_RVALID_OUT &&
      REG_RDATA_OUT == ($past(BATT_MV_IN) > `BATT_MAX_MV ? `BATT_MAX_MV :
      $past(BATT_MV_IN))) else $error("battery word wrong");
   AST_HEIGHT: assert property (
      rd && REG_ADDR_IN == `ADDR_HEIGHT_LO && LEVEL_MONITOR_OPTION_IN &&
      $stable(LEVEL_MONITOR_OPTION_IN) && $stable(LEVEL_HEIGHT_IN) &&
      $past(CE_IN) && !$past(RST_IN) |=> REG_RDATA_OUT ==
      ($past(LEVEL_HEIGHT_IN) > `HEIGHT_MAX ? `HEIGHT_MAX :
      $past(LEVEL_HEIGHT_IN))) else $error("height wrong");
   AST_NO_MONITOR: assert property (
      rd && REG_ADDR_IN == `ADDR_HEIGHT_LO && !LEVEL_MONITOR_OPTION_IN &&
      $stable(LEVEL_MONITOR_OPTION_IN) && $past(CE_IN) |=>
      REG_RDATA_OUT == 16'h0000) else $error("height without monitor");
   AST_UPPER_ZERO: assert property (
      rd && (REG_ADDR_IN == `ADDR_BATT_HI || REG_ADDR_IN == `ADDR_ALARM_HI
      || REG_ADDR_IN == `ADDR_HEIGHT_HI || REG_ADDR_IN == `ADDR_PPV_HI ||
      REG_ADDR_IN == `ADDR_PUMP_HI) |=> REG_RDATA_OUT == 16'h0000)
      else $error("upper word not zero");
   AST_TOT_CLR: assert property (
      wr && REG_ADDR_IN == `ADDR_TOTAL_CLEAR_LO && REG_WDATA_IN == 16'h0001
      && tot_hi_ff == 16'h0000 |=> TOTAL_CLEARED_OUT &&
      TOTAL_VOLUME_OUT == 32'h00000000) else $error("total not cleared");
   AST_TOT_NOP: assert property (
      wr && REG_ADDR_IN == `ADDR_TOTAL_CLEAR_LO && REG_WDATA_IN == 16'h0000
      |=> !TOTAL_CLEARED_OUT) else $error("total cleared by zero");
   AST_ALM_CLR: assert property (
      wr && REG_ADDR_IN == `ADDR_ALARM_CLEAR_LO && REG_WDATA_IN == 16'h0001
      && alm_hi_ff == 16'h0000 |-> ##2 ALARM_CLEARED_OUT)
      else $error("alarms not cleared");
   AST_ALM_NOP: assert property (
      wr && REG_ADDR_IN == `ADDR_ALARM_CLEAR_LO && REG_WDATA_IN == 16'h0000
      |-> ##2 !ALARM_CLEARED_OUT) else $error("alarms cleared by zero");
   AST_ALM_SET: assert property (
      CE_IN ##1 CE_IN |=> (ALARM_FLAGS_OUT & $past(ALARM_SRC_IN, 2) &
      `ALM_USED_MASK) == ($past(ALARM_SRC_IN, 2) & `ALM_USED_MASK))
      else $error("alarm source not latched");
   AST_UNUSED_BITS: assert property (
      1'b1 |-> !ALARM_FLAGS_OUT[0] && !ALARM_FLAGS_OUT[11])
      else $error("unused alarm bit set");
endmodule
bind inj_status_regs status_chk #(.ADDR_W(ADDR_W)) chk (.*);

//--- test/testbench.sv
/* self-checking bench for the status register bank.
   inputs change at falling edges; the master model makes accesses */
`include "inj_regs_defines.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [19:0] a; logic [15:0] v; logic o; logic [15:0] x;}
      row_t;
   logic        clk = 1'b0, rst = 1'b1, vp = 1'b0, opt = 1'b1, ce = 1'b1;
   logic [15:0] val = 16'h1234, src = 16'h0000, rdata, wdata, flags, d;
   logic [19:0] addr;
   logic        wr, rd, rv, err, e, tc, ac;
   logic [31:0] tot;
   int          fails = 0, n_tests = 0, cyc = 0;
   row_t rows [13] = '{'{`ADDR_BATT_HI, 16'h1234, 1, 16'h0000},
      '{`ADDR_ALARM_CLEAR_LO, 16'h1234, 1, 16'h0000},
      '{`ADDR_BATT_LO, 16'h1234, 1, 16'h1234},
      '{`ADDR_BATT_LO, 16'hFFFF, 1, 16'hC350},
      '{`ADDR_HEIGHT_HI, 16'h1234, 1, 16'h0000},
      '{`ADDR_HEIGHT_LO, 16'h3840, 1, 16'h3840},
      '{`ADDR_HEIGHT_LO, 16'h3841, 1, 16'h3840},
      '{`ADDR_HEIGHT_LO, 16'h1234, 0, 16'h0000},
      '{`ADDR_ALARM_HI, 16'h1234, 1, 16'h0000},
      '{`ADDR_PPV_HI, 16'h1234, 1, 16'h0000},
      '{`ADDR_PPV_LO, 16'h0000, 1, 16'h0001},
      '{`ADDR_PPV_LO, 16'h2710, 1, 16'h270F},
      '{`ADDR_PUMP_HI, 16'h1234, 1, 16'h0000}};
   always #25 clk = ~clk;
   inj_status_regs dut (.CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce),
      .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_RD_IN(rd),
      .REG_WDATA_IN(wdata), .BATT_MV_IN(val), .ALARM_SRC_IN(src),
      .LEVEL_HEIGHT_IN(val), .LEVEL_MONITOR_OPTION_IN(opt),
      .PULSE_PER_VOLUME_IN(val), .VOLUME_PULSE_IN(vp),
      .VOLUME_STEP_IN(16'h0005), .REG_RDATA_OUT(rdata),
      .REG_RVALID_OUT(rv), .REG_ERR_OUT(err), .TOTAL_VOLUME_OUT(tot),
      .TOTAL_CLEARED_OUT(tc), .ALARM_CLEARED_OUT(ac),
      .ALARM_FLAGS_OUT(flags));
   modbus_master mst (.clk_in(clk), .rvalid_in(rv), .err_in(err),
      .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
      .wdata_out(wdata));
   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         $display("wrong value %s expected %h seen %h", n, x, g);
         fails++;
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // cut a hang short: the whole run needs about a hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      chk("total", 0, tot);
      chk("flags", 0, {16'h0000, flags});
      $display("test reset done");
      foreach (rows[i]) begin
         @(negedge clk);
         val = rows[i].v;
         opt = rows[i].o;
         mst.rd_reg(rows[i].a, d, e);
         chk("status word", rows[i].x, d);
         chk("status err", 0, e);
      end
      $display("test table done");
      repeat (3) begin
         @(negedge clk);
         vp = 1'b1;
         @(negedge clk);
         vp = 1'b0;
      end
      mst.wr_reg(`ADDR_BATT_LO, 16'h0000);
      mst.rd_reg(`ADDR_BATT_LO, d, e);
      chk("ro battery", 16'h1234, d);
      chk("ro total", 32'h0000000F, tot);
      mst.wr32(`ADDR_TOTAL_CLEAR_HI, 32'h00000000);
      chk("total kept", 32'h0000000F, tot);
      chk("no total pulse", 0, tc);
      mst.wr32(`ADDR_TOTAL_CLEAR_HI, 32'h00000001);
      chk("total zero", 0, tot);
      chk("total pulse", 1, tc);
      $display("test totalizer done");
      @(negedge clk);
      ce = 1'b0;
      vp = 1'b1;
      @(negedge clk);
      ce = 1'b1;
      vp = 1'b0;
      chk("frozen total", 0, tot);
      $display("test clock enable done");
      @(negedge clk);
      src = 16'hFFFF;
      @(negedge clk);
      src = 16'h0000;
      mst.rd_reg(`ADDR_ALARM_LO, d, e);
      chk("alarm word", 16'h77FE, d);
      mst.wr32(`ADDR_ALARM_CLEAR_HI, 32'h00000000);
      repeat (3) @(negedge clk);
      chk("alarm kept", 16'h77FE, flags);
      mst.wr32(`ADDR_ALARM_CLEAR_HI, 32'h00000001);
      @(negedge clk);
      chk("alarm pulse", 1, ac);
      @(negedge clk);
      chk("alarm flags", 0, flags);
      mst.rd_reg(20'h61F03, d, e);
      chk("unmapped err", 1, e);
      chk("unmapped data", 0, d);
      $display("test alarms done");
      give_verdict();
   end
endmodule
